/* verilog/iopdm_consts.vh */
// constants for the pin drive mode controller: offsets, fields, reset values
`ifndef IOPDM_CONSTS_VH
`define IOPDM_CONSTS_VH
// avalon word byte addresses
`define IOPDM_OFS_OUT      8'h00
`define IOPDM_OFS_BYP      8'h04
`define IOPDM_OFS_DM0      8'h08
`define IOPDM_OFS_DM1      8'h0C
`define IOPDM_OFS_DM2      8'h10
`define IOPDM_OFS_RSTCFG   8'h14
`define IOPDM_OFS_CTRL     8'h18
`define IOPDM_OFS_PIN      8'h1C
`define IOPDM_OFS_INTEN    8'h20
`define IOPDM_OFS_INTST    8'h24
// drive mode codes
`define IOPDM_DM_HIZ_ANA   3'h0
`define IOPDM_DM_HIZ_DIG   3'h1
`define IOPDM_DM_RES_UP    3'h2
`define IOPDM_DM_RES_DN    3'h3
`define IOPDM_DM_OD_LOW    3'h4
`define IOPDM_DM_OD_HIGH   3'h5
`define IOPDM_DM_STRONG    3'h6
`define IOPDM_DM_RES_BOTH  3'h7
// reset configuration field codes
`define IOPDM_RC_HIZ       2'h0
`define IOPDM_RC_PULLDN    2'h1
`define IOPDM_RC_PULLUP    2'h2
// control register bit positions
`define IOPDM_CTRL_LP_BIT  0
`define IOPDM_CTRL_NVLD_BIT 1
`endif

/* verilog/iopdm_pin_drive.v */
// one pin: decodes drive mode code and data into pad drive controls
`timescale 1ns/1ps
`include "iopdm_consts.vh"
module iopdm_pin_drive (
    input wire [2:0] mode,   // drive_mode_field
    input wire data,         // selected output value
    output reg strong_hi,    // strong drive high enable
    output reg strong_lo,    // strong drive low enable
    output reg res_hi,       // resistive pull-up enable
    output reg res_lo,       // resistive pull-down enable
    output reg dig_in_en     // digital input buffer enable
);
    // eight behaviours, one per code
    always @* begin
        strong_hi = 1'b0;
        strong_lo = 1'b0;
        res_hi = 1'b0;
        res_lo = 1'b0;
        dig_in_en = 1'b1;
        case (mode)
            `IOPDM_DM_HIZ_ANA: begin
                dig_in_en = 1'b0;
            end
            `IOPDM_DM_HIZ_DIG: begin
                dig_in_en = 1'b1;
            end
            `IOPDM_DM_RES_UP: begin
                res_hi = data;
                strong_lo = ~data;
            end
            `IOPDM_DM_RES_DN: begin
                strong_hi = data;
                res_lo = ~data;
            end
            `IOPDM_DM_OD_LOW: begin
                strong_lo = ~data;
            end
            `IOPDM_DM_OD_HIGH: begin
                strong_hi = data;
            end
            `IOPDM_DM_STRONG: begin
                strong_hi = data;
                strong_lo = ~data;
            end
            default: begin
                res_hi = data;
                res_lo = ~data;
            end
        endcase
    end
endmodule

/* verilog/iopdm_port.v */
// one gpio port: per-pin drive modes, reset configuration, retention, wake
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`include "iopdm_consts.vh"
module iopdm_port #(
    parameter WIDTH = 8 // pins in the port
) (
    input wire clk,                       // 100 MHz system clock
    input wire rstn,                      // synchronous reset, active low
    input wire [7:0] avs_address,         // byte address
    input wire avs_read,                  // read strobe
    input wire avs_write,                 // write strobe
    input wire [31:0] avs_writedata,      // write data
    input wire [3:0] avs_byteenable,      // byte lanes
    output reg [31:0] avs_readdata,       // read data
    output reg avs_waitrequest,           // stall
    input wire [1:0] nv_reset_cfg,        // nonvolatile reset config value
    input wire [WIDTH-1:0] routed_in,     // internally routed signals
    input wire [WIDTH-1:0] pin_in,        // pad input levels
    output reg [WIDTH-1:0] pad_strong_hi, // strong high enables
    output reg [WIDTH-1:0] pad_strong_lo, // strong low enables
    output reg [WIDTH-1:0] pad_res_hi,    // resistive pull-up enables
    output reg [WIDTH-1:0] pad_res_lo,    // resistive pull-down enables
    output reg [WIDTH-1:0] pad_dig_in_en, // digital input buffer enables
    output reg wake                       // pin interrupt wake, level
);
    reg [WIDTH-1:0] port_output_value;
    reg [WIDTH-1:0] bypass_sel;
    reg [WIDTH-1:0] port_drive_mode_bits [0:2];
    reg [1:0] port_reset_cfg;
    reg low_power;
    reg nv_loaded;
    reg in_reset_d;
    reg [WIDTH-1:0] int_en;
    reg [WIDTH-1:0] int_status;
    reg [WIDTH-1:0] pin_prev;
    reg bus_done;
    wire [WIDTH-1:0] drive_data;
    wire [WIDTH-1:0] dec_shi;
    wire [WIDTH-1:0] dec_slo;
    wire [WIDTH-1:0] dec_rhi;
    wire [WIDTH-1:0] dec_rlo;
    wire [WIDTH-1:0] dec_din;
    wire [WIDTH-1:0] pin_edge;
    wire bus_req;
    wire wr_now;
    wire rd_now;
    wire [WIDTH-1:0] wmask;
    wire [WIDTH-1:0] wdat;

    // apply byte enables to a narrow register write
    function [WIDTH-1:0] merge;
        input [WIDTH-1:0] old_val;
        input [WIDTH-1:0] new_val;
        input [WIDTH-1:0] m;
        begin
            merge = (old_val & ~m) | (new_val & m);
        end
    endfunction

    // bypass picks the routed signal per pin
    assign drive_data = (port_output_value & ~bypass_sel) | (routed_in & bypass_sel);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
            iopdm_pin_drive u_drive (
                .mode({port_drive_mode_bits[2][i], port_drive_mode_bits[1][i],
                       port_drive_mode_bits[0][i]}),
                .data(drive_data[i]),
                .strong_hi(dec_shi[i]),
                .strong_lo(dec_slo[i]),
                .res_hi(dec_rhi[i]),
                .res_lo(dec_rlo[i]),
                .dig_in_en(dec_din[i])
            );
            assign wmask[i] = avs_byteenable[i / 8];
        end
    endgenerate

    // one wait state: every access answers on its second edge
    assign bus_req = avs_read | avs_write;
    assign wr_now = avs_write & ~avs_waitrequest;
    assign rd_now = avs_read & ~avs_waitrequest;
    assign wdat = avs_writedata[WIDTH-1:0];

    always @(posedge clk) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
            bus_done <= 1'b0;
        end else begin
            avs_waitrequest <= ~(bus_req & ~bus_done);
            bus_done <= bus_req & ~bus_done;
        end
    end

    // register writes; reset returns every mode to analog high-z
    always @(posedge clk) begin
        if (!rstn) begin
            port_output_value <= {WIDTH{1'b0}};
            bypass_sel <= {WIDTH{1'b0}};
            port_drive_mode_bits[0] <= {WIDTH{1'b0}};
            port_drive_mode_bits[1] <= {WIDTH{1'b0}};
            port_drive_mode_bits[2] <= {WIDTH{1'b0}};
            low_power <= 1'b0;
            int_en <= {WIDTH{1'b0}};
        end else begin
            if (wake) begin
                low_power <= 1'b0; // wake returns to active
            end
            if (wr_now) begin
                if (avs_address == `IOPDM_OFS_OUT) begin
                    port_output_value <= merge(port_output_value, wdat, wmask);
                end else if (avs_address == `IOPDM_OFS_BYP) begin
                    bypass_sel <= merge(bypass_sel, wdat, wmask);
                end else if (avs_address == `IOPDM_OFS_DM0) begin
                    port_drive_mode_bits[0] <= merge(port_drive_mode_bits[0], wdat, wmask);
                end else if (avs_address == `IOPDM_OFS_DM1) begin
                    port_drive_mode_bits[1] <= merge(port_drive_mode_bits[1], wdat, wmask);
                end else if (avs_address == `IOPDM_OFS_DM2) begin
                    port_drive_mode_bits[2] <= merge(port_drive_mode_bits[2], wdat, wmask);
                end else if (avs_address == `IOPDM_OFS_CTRL && avs_byteenable[0]) begin
                    low_power <= avs_writedata[`IOPDM_CTRL_LP_BIT];
                end else if (avs_address == `IOPDM_OFS_INTEN) begin
                    int_en <= merge(int_en, wdat, wmask);
                end
            end
        end
    end

    // copy stored reset config one edge after release, no firmware needed
    always @(posedge clk) begin
        if (!rstn) begin
            in_reset_d <= 1'b1;
            nv_loaded <= 1'b0;
            port_reset_cfg <= `IOPDM_RC_HIZ;
        end else begin
            in_reset_d <= 1'b0;
            if (in_reset_d) begin
                port_reset_cfg <= nv_reset_cfg;
                nv_loaded <= 1'b1;
            end else if (wr_now && avs_address == `IOPDM_OFS_RSTCFG && avs_byteenable[0]) begin
                port_reset_cfg <= avs_writedata[1:0];
            end
        end
    end

    // pin change detection runs regardless of low_power
    assign pin_edge = (pin_in ^ pin_prev) & int_en;
    always @(posedge clk) begin
        if (!rstn) begin
            pin_prev <= {WIDTH{1'b0}};
            int_status <= {WIDTH{1'b0}};
            wake <= 1'b0;
        end else begin
            pin_prev <= pin_in;
            // set wins over a clear in the same cycle
            if (wr_now && avs_address == `IOPDM_OFS_INTST) begin
                int_status <= (int_status & ~(wdat & wmask)) | pin_edge;
            end else begin
                int_status <= int_status | pin_edge;
            end
            wake <= low_power & (|pin_edge);
        end
    end

    // pad drivers: reset high-z, retained in low power, reset pulls on
    // each pin still in analog high-z, else decoded modes
    always @(posedge clk) begin
        if (!rstn) begin
            pad_strong_hi <= {WIDTH{1'b0}};
            pad_strong_lo <= {WIDTH{1'b0}};
            pad_res_hi <= {WIDTH{1'b0}};
            pad_res_lo <= {WIDTH{1'b0}};
            pad_dig_in_en <= {WIDTH{1'b0}};
        end else if (low_power) begin
            pad_strong_hi <= pad_strong_hi;
            pad_strong_lo <= pad_strong_lo;
            pad_res_hi <= pad_res_hi;
            pad_res_lo <= pad_res_lo;
            pad_dig_in_en <= pad_dig_in_en;
        end else begin
            pad_strong_hi <= dec_shi;
            pad_strong_lo <= dec_slo;
            // reset pull applies to pins still in code 000
            // only code 000 clears the input buffer, so it marks the pins that get the pull
            pad_res_hi <= dec_rhi |
                (~dec_din & {WIDTH{port_reset_cfg == `IOPDM_RC_PULLUP}});
            pad_res_lo <= dec_rlo |
                (~dec_din & {WIDTH{port_reset_cfg == `IOPDM_RC_PULLDN}});
            pad_dig_in_en <= dec_din;
        end
    end

    // read mux
    always @(posedge clk) begin
        if (!rstn) begin
            avs_readdata <= 32'h00000000;
        end else if (bus_req && avs_waitrequest) begin
            avs_readdata <= 32'h00000000;
            if (avs_address == `IOPDM_OFS_OUT) begin
                avs_readdata[WIDTH-1:0] <= port_output_value;
            end else if (avs_address == `IOPDM_OFS_BYP) begin
                avs_readdata[WIDTH-1:0] <= bypass_sel;
            end else if (avs_address == `IOPDM_OFS_DM0) begin
                avs_readdata[WIDTH-1:0] <= port_drive_mode_bits[0];
            end else if (avs_address == `IOPDM_OFS_DM1) begin
                avs_readdata[WIDTH-1:0] <= port_drive_mode_bits[1];
            end else if (avs_address == `IOPDM_OFS_DM2) begin
                avs_readdata[WIDTH-1:0] <= port_drive_mode_bits[2];
            end else if (avs_address == `IOPDM_OFS_RSTCFG) begin
                avs_readdata[1:0] <= port_reset_cfg;
            end else if (avs_address == `IOPDM_OFS_CTRL) begin
                avs_readdata[`IOPDM_CTRL_LP_BIT] <= low_power;
                avs_readdata[`IOPDM_CTRL_NVLD_BIT] <= nv_loaded;
            end else if (avs_address == `IOPDM_OFS_PIN) begin
                avs_readdata[WIDTH-1:0] <= pin_in;
            end else if (avs_address == `IOPDM_OFS_INTEN) begin
                avs_readdata[WIDTH-1:0] <= int_en;
            end else if (avs_address == `IOPDM_OFS_INTST) begin
                avs_readdata[WIDTH-1:0] <= int_status;
            end
        end
    end
endmodule

/* bench/iopdm_pads.sv */
// far-side pad circuits: turn drive controls into pin levels
`timescale 1ns/1ps
module iopdm_pads #(
    parameter WIDTH = 8 // pins watched
) (
    input wire [WIDTH-1:0] s_hi, // strong high enables
    input wire [WIDTH-1:0] s_lo, // strong low enables
    input wire [WIDTH-1:0] r_hi, // resistive up enables
    input wire [WIDTH-1:0] r_lo, // resistive down enables
    input wire [WIDTH-1:0] ext,  // far-side level on released pins
    output logic [WIDTH-1:0] lvl // resolved pin level
);
    // strong beats resistive; a released pin follows the far side, never the old value
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            if (s_hi[i] | s_lo[i])
                lvl[i] = s_hi[i];
            else if (r_hi[i] | r_lo[i])
                lvl[i] = r_hi[i];
            else
                lvl[i] = ext[i];
        end
    end
endmodule

/* bench/iopdm_port_chk.sv */
// assertions on the port block's bus handshake and pad controls
`timescale 1ns/1ps
`include "iopdm_consts.vh"
module iopdm_port_chk #(
    parameter WIDTH = 8 // pins in the port
) (
    input wire clk, // clock
    input wire rstn, // sync reset, low
    input wire [7:0] avs_address, // address
    input wire avs_read, // read
    input wire avs_write, // write
    input wire [31:0] avs_writedata, // write data
    input wire [3:0] avs_byteenable, // lanes
    input wire [31:0] avs_readdata, // read data
    input wire avs_waitrequest, // stall
    input wire [WIDTH-1:0] pad_strong_hi, // pads
    input wire [WIDTH-1:0] pad_strong_lo, // pads
    input wire [WIDTH-1:0] pad_res_hi, // pads
    input wire [WIDTH-1:0] pad_res_lo, // pads
    input wire [WIDTH-1:0] pad_dig_in_en, // pads
    input wire wake // wake level
);
    logic lp;
    wire req = avs_read | avs_write;
    wire [WIDTH-1:0] hi = pad_strong_hi | pad_res_hi;
    wire [WIDTH-1:0] lo = pad_strong_lo | pad_res_lo;
    wire [4*WIDTH-1:0] pads = {pad_strong_hi, pad_strong_lo, pad_res_hi, pad_res_lo};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // mirror of the low-power bit; cleared on wake at the same edge as in the port
    always @(posedge clk) begin
        if (!rstn || wake)
            lp <= 1'b0;
        else if (avs_write && !avs_waitrequest && avs_address == `IOPDM_OFS_CTRL)
            lp <= avs_byteenable[0] ? avs_writedata[0] : lp;
    end
    a_reset_hiz: assert property (disable iff (1'b0) !rstn |=>
        (hi | lo | pad_dig_in_en) == 0 && avs_waitrequest && !wake)
        else $error("pads not released in reset");
    a_no_fight: assert property ((hi & lo) == 0)
        else $error("pad pulled both ways");
    a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_answer_next: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered");
    a_wait_cause: assert property (!avs_waitrequest |-> $past(req))
        else $error("answer without request");
    a_unmapped_zero: assert property (avs_read && avs_waitrequest && avs_address > 8'h24
        |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_lp_freeze: assert property (lp && $past(lp) |-> $stable(pads))
        else $error("pads moved in low power");
    a_wake_lp: assert property ($rose(wake) |-> lp)
        else $error("wake outside low power");
    c_wake: cover property ($rose(wake));
    c_read: cover property (avs_read && !avs_waitrequest);
    c_write: cover property (avs_write && !avs_waitrequest);
endmodule
bind iopdm_port iopdm_port_chk #(.WIDTH(WIDTH)) u_chk (.clk, .rstn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .pad_strong_hi, .pad_strong_lo, .pad_res_hi, .pad_res_lo, .pad_dig_in_en, .wake);

/* bench/iopdm_port_tb.sv */
// self-checking bench for the pin drive mode port
`timescale 1ns/1ps
`include "iopdm_consts.vh"
module iopdm_port_tb;
    logic clk = 0, rstn = 0, rd_s = 0, wr_s = 0, wreq, wake;
    logic [7:0] adr = 0, routed = 0, ext = 0, pin, sh, sl, rh, rl, di, o, b, d0, d1, d2;
    logic [31:0] wd = 0, rdat, q;
    logic [3:0] be = 4'hF;
    logic [1:0] nv = 2'h1, rc;
    int mismatches = 0, cmp_count = 0, seed = 32231, n;
    iopdm_port u_iopdm_port (.clk, .rstn, .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
        .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wreq),
        .nv_reset_cfg(nv), .routed_in(routed), .pin_in(pin), .pad_strong_hi(sh),
        .pad_strong_lo(sl), .pad_res_hi(rh), .pad_res_lo(rl), .pad_dig_in_en(di), .wake);
    iopdm_pads u_iopdm_pads (.s_hi(sh), .s_lo(sl), .r_hi(rh), .r_lo(rl), .ext, .lvl(pin));
    always #5 clk = ~clk;
    // one access, held until waitrequest is sampled low
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        begin
            adr <= a;
            wd <= d;
            wr_s <= w;
            rd_s <= !w;
            @(posedge clk);
            while (wreq !== 1'b0) @(posedge clk);
            q = rdat;
            rd_s <= 0;
            wr_s <= 0;
            @(posedge clk);
        end
    endtask
    task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        begin
            cmp_count++;
            if (g !== e) begin
                mismatches++;
                $display("FAIL %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task stop_test;
        begin
            if (mismatches == 0 && cmp_count > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // expected {strong hi, strong lo, res hi, res lo} of one pin
    function automatic logic [3:0] dexp(input logic [2:0] m, input logic v, input logic [1:0] r);
        case (m)
            3'h0: dexp = (r == 2'h1) ? 4'h1 : (r == 2'h2) ? 4'h2 : 4'h0;
            3'h2: dexp = v ? 4'h2 : 4'h4;
            3'h3: dexp = v ? 4'h8 : 4'h1;
            3'h4: dexp = v ? 4'h0 : 4'h4;
            3'h5: dexp = v ? 4'h8 : 4'h0;
            3'h6: dexp = v ? 4'h8 : 4'h4;
            3'h7: dexp = v ? 4'h2 : 4'h1;
            default: dexp = 4'h0;
        endcase
    endfunction
    task chk_pads;
        logic [7:0] xs, xl, xr, xf, xd, v;
        begin
            v = (o & ~b) | (routed & b);
            for (int i = 0; i < 8; i++) begin
                {xs[i], xl[i], xr[i], xf[i]} = dexp({d2[i], d1[i], d0[i]}, v[i], rc);
                xd[i] = ({d2[i], d1[i], d0[i]} != 3'h0);
            end
            chk("pads", {xs, xl, xr, xf, xd}, {sh, sl, rh, rl, di});
        end
    endtask
    task setregs;
        begin
            acc(1, `IOPDM_OFS_OUT, o);
            acc(1, `IOPDM_OFS_BYP, b);
            acc(1, `IOPDM_OFS_DM0, d0);
            acc(1, `IOPDM_OFS_DM1, d1);
            acc(1, `IOPDM_OFS_DM2, d2);
            acc(1, `IOPDM_OFS_RSTCFG, rc);
            @(posedge clk);
        end
    endtask
    // watchdog sized well above the expected run
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        stop_test;
    end
    initial begin
        repeat (6) @(posedge clk);
        chk("pads_in_reset", 0, sh | sl | rh | rl | di);
        rstn <= 1;
        @(posedge clk);
        acc(0, `IOPDM_OFS_RSTCFG, 0);
        chk("rstcfg_copy", nv, q);
        acc(0, `IOPDM_OFS_CTRL, 0);
        chk("nv_loaded", 1, q[1]);
        // every code on its own pin, both data values
        {d0, d1, d2, b, rc} = {8'hAA, 8'hCC, 8'hF0, 8'h00, 2'h2};
        for (int k = 0; k < 2; k++) begin
            o = k ? 8'h00 : 8'hFF;
            setregs;
            chk_pads;
        end
        repeat (40) begin
            {o, b, d0, d1, d2} = {8'($random(seed)), 8'($random(seed)), 24'($random(seed))};
            rc = 2'($unsigned($random(seed)) % 3);
            routed <= 8'($random(seed));
            ext <= 8'($random(seed));
            setregs;
            chk_pads;
            acc(0, `IOPDM_OFS_OUT, 0);
            chk("out_readback", o, q);
        end
        acc(0, 8'h28, 0);
        chk("unmapped_read", 0, q);
        // a write with the pin lane switched off must leave the data untouched
        be <= 4'hE;
        acc(1, `IOPDM_OFS_OUT, {24'h000000, ~o});
        be <= 4'hF;
        acc(0, `IOPDM_OFS_OUT, 0);
        chk("lane_off", o, q);
        // reset in mid-run while pins are driven
        rstn <= 0;
        nv <= 2'h2;
        repeat (2) @(posedge clk);
        chk("pads_in_reset", 0, sh | sl | rh | rl | di);
        rstn <= 1;
        @(posedge clk);
        acc(0, `IOPDM_OFS_RSTCFG, 0);
        chk("rstcfg_copy", 2'h2, q);
        // low power: upper pins released to a bus-safe code, lower pins strong
        {d0, d1, d2, o, b, rc} = {8'h00, 8'h0F, 8'h0F, 8'h05, 8'h00, 2'h0};
        ext <= 0;
        setregs;
        acc(1, `IOPDM_OFS_INTEN, 32'hF0);
        acc(1, `IOPDM_OFS_INTST, 32'hFF);
        acc(1, `IOPDM_OFS_CTRL, 32'h1);
        o = 8'h0A;
        acc(1, `IOPDM_OFS_OUT, o);
        @(posedge clk);
        chk("frozen_pads", 8'h05, sh);
        ext <= 8'hF0;
        n = 0;
        while (wake !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        chk("wake", 1, wake);
        repeat (3) @(posedge clk);
        chk_pads;
        acc(0, `IOPDM_OFS_INTST, 0);
        chk("int_status", 32'h000000F0, q);
        acc(0, `IOPDM_OFS_CTRL, 0);
        chk("ctrl_after_wake", 32'h00000002, q);
        stop_test;
    end
endmodule
